// File: dpl_consts.vh
// Purpose: Constants for the DSP program image loader
// Assumes: Byte stream from the boot EEPROM byte engine
// Notes:   Offsets count bytes from the first byte of a block
`ifndef DPL_CONSTS_VH
`define DPL_CONSTS_VH
`define DPL_HDR_BYTES     8'h0c
`define DPL_WORD_BYTES    3'h7
`define DPL_TRL_ZEROS     3'h5
`define DPL_TERM_ID_HI    8'h00
`define DPL_TERM_ID_LO    8'h1f
`define DPL_TERM_ZEROS    5'h10
`define DPL_TERM_LEN      5'h14
`define DPL_TERM_HI_POS   5'h02
`define DPL_TERM_LO_POS   5'h03
`define DPL_LOW_MSB       47
`define DPL_WORD_MASK     56'h3f_ffff_ffff_ffff
`define DPL_VALID_BITS    54
`endif

// File: dpl_word_pack.v
// Purpose: Packs seven bytes into one program word
// Assumes: Bytes arrive least significant first
// Notes:   Index selects the byte lane
`timescale 1ns/1ps
`include "dpl_consts.vh"
module dpl_word_pack (
  // Clock and reset
  input  wire        clock,
  input  wire        resetn,
  // Byte in
  input  wire        load,
  input  wire [2:0]  index,
  input  wire [7:0]  data,
  // Word out
  output wire [55:0] word
);
  genvar g;
  generate
    for (g = 0; g < `DPL_WORD_BYTES; g = g + 1) begin : lane
      localparam [2:0] LANE = g;
      reg [7:0] byte_q;
      always @(posedge clock or negedge resetn) begin
        if (!resetn)
          byte_q <= 8'h00;
        else if (load && index == LANE)
          byte_q <= data;
      end
      assign word[8*g+7:8*g] = byte_q;
    end
  endgenerate
endmodule

// File: dpl_loader.v
// Purpose: Parses program-memory and termination blocks of the boot image
// Assumes: Header parser gives block type and payload length ahead of payload
// Notes:   One byte per valid cycle; block begins with first payload byte
//          After the termination block the loader halts until reset
`timescale 1ns/1ps
`include "dpl_consts.vh"
module dpl_loader #(
  parameter AW = 12,
  parameter LW = 16
) (
  // Clock and reset
  input  wire          clock,
  input  wire          resetn,
  // Block start, from header parser
  input  wire          blk_start,
  input  wire          blk_term,
  input  wire [LW-1:0] blk_words,
  input  wire [15:0]   blk_sum_init,
  // Byte stream
  input  wire          byte_valid,
  input  wire [7:0]    byte_data,
  output wire          byte_ready,
  // Program memory write
  output reg           pm_we,
  output reg  [AW-1:0] pm_addr,
  output reg  [55:0]   pm_data,
  // Status
  output reg           busy,
  output reg           pm_done,
  output reg           pm_error,
  output reg           term_error,
  output reg           load_done
);
  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_WORD = 3'h1;
  localparam S_TZERO = 3'h2;
  localparam S_TMS = 3'h3;
  localparam S_TLS = 3'h4;
  localparam S_TERM = 3'h5;
  localparam S_STOP = 3'h6;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [2:0]    state_q;
  reg [2:0]    bidx_q;
  reg [LW-1:0] wleft_q;
  reg [15:0]   sum_q;
  reg [7:0]    ck_ms_q;
  reg [4:0]    tcnt_q;
  reg          tbad_q;
  reg [AW-1:0] next_addr_q;
  wire [55:0]  word;
  wire         take;
  wire [15:0]  sum_add;
  wire         word_end;

  // ----------------------------------------------------------------
  // Byte handshake
  // ----------------------------------------------------------------
  assign take = byte_valid && byte_ready;
  assign byte_ready = (state_q != S_IDLE) && (state_q != S_STOP);
  assign sum_add = sum_q + {8'h00, byte_data};
  assign word_end = take && (state_q == S_WORD) && (bidx_q == `DPL_WORD_BYTES - 3'h1);

  // ----------------------------------------------------------------
  // Word packer
  // ----------------------------------------------------------------
  dpl_word_pack u_pack (
    .clock  (clock),
    .resetn (resetn),
    .load   (take && state_q == S_WORD),
    .index  (bidx_q),
    .data   (byte_data),
    .word   (word)
  );

  // ----------------------------------------------------------------
  // Running checksum
  // ----------------------------------------------------------------
  // Trailer zeros and checksum bytes stay out of the sum
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      sum_q <= 16'h0000;
    else if (state_q == S_IDLE && blk_start && !blk_term)
      sum_q <= blk_sum_init;
    else if (take && state_q == S_WORD)
      sum_q <= sum_add;
  end

  // ----------------------------------------------------------------
  // Program memory write
  // ----------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pm_we       <= 1'b0;
      pm_addr     <= {AW{1'b0}};
      pm_data     <= 56'h0;
      next_addr_q <= {AW{1'b0}};
    end else begin
      pm_we <= word_end;
      if (word_end) begin
        pm_addr     <= next_addr_q;
        // Bits above the valid field are forced to zero
        pm_data     <= {byte_data, word[`DPL_LOW_MSB:0]} & `DPL_WORD_MASK;
        next_addr_q <= next_addr_q + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Block parser
  // ----------------------------------------------------------------
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q     <= S_IDLE;
      bidx_q      <= 3'h0;
      wleft_q     <= {LW{1'b0}};
      ck_ms_q     <= 8'h00;
      tcnt_q      <= 5'h00;
      tbad_q      <= 1'b0;
      busy        <= 1'b0;
      pm_done     <= 1'b0;
      pm_error    <= 1'b0;
      term_error  <= 1'b0;
      load_done   <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (blk_start) begin
            busy   <= 1'b1;
            bidx_q <= 3'h0;
            tcnt_q <= 5'h00;
            tbad_q <= 1'b0;
            if (blk_term) begin
              state_q <= S_TERM;
            end else begin
              // Payload follows header at block byte 12
              wleft_q  <= blk_words;
              pm_error <= 1'b1;
              pm_done  <= 1'b0;
              state_q  <= (blk_words == {LW{1'b0}}) ? S_TZERO : S_WORD;
            end
          end
        end
        S_WORD: begin
          if (take) begin
            if (word_end) begin
              bidx_q  <= 3'h0;
              wleft_q <= wleft_q - {{(LW-1){1'b0}}, 1'b1};
              if (wleft_q == {{(LW-1){1'b0}}, 1'b1})
                state_q <= S_TZERO;
            end else begin
              bidx_q <= bidx_q + 3'h1;
            end
          end
        end
        S_TZERO: begin
          if (take) begin
            // Trailer bytes count as zero in the sum
            if (byte_data != 8'h00)
              tbad_q <= 1'b1;
            if (bidx_q == `DPL_TRL_ZEROS - 3'h1) begin
              bidx_q  <= 3'h0;
              state_q <= S_TMS;
            end else begin
              bidx_q <= bidx_q + 3'h1;
            end
          end
        end
        S_TMS: begin
          if (take) begin
            ck_ms_q <= byte_data;
            state_q <= S_TLS;
          end
        end
        S_TLS: begin
          if (take) begin
            busy    <= 1'b0;
            state_q <= S_IDLE;
            // Error stays set unless the trailer zeros are clean and the checksum matches
            if (!tbad_q && {ck_ms_q, byte_data} == sum_q) begin
              pm_error <= 1'b0;
              pm_done  <= 1'b1;
            end else begin
              pm_done  <= 1'b0;
            end
          end
        end
        S_TERM: begin
          if (take) begin
            tcnt_q <= tcnt_q + 5'h01;
            // Each termination byte checked against its fixed value
            if (tcnt_q == `DPL_TERM_HI_POS && byte_data != `DPL_TERM_ID_HI)
              tbad_q <= 1'b1;
            else if (tcnt_q == `DPL_TERM_LO_POS && byte_data != `DPL_TERM_ID_LO)
              tbad_q <= 1'b1;
            else if (tcnt_q < `DPL_TERM_HI_POS && byte_data != 8'h00)
              tbad_q <= 1'b1;
            else if (tcnt_q >= `DPL_TERM_LEN - `DPL_TERM_ZEROS && byte_data != 8'h00)
              tbad_q <= 1'b1;
            if (tcnt_q == `DPL_TERM_LEN - 5'h01) begin
              // Last block: stop accepting bytes
              busy       <= 1'b0;
              load_done  <= 1'b1;
              term_error <= tbad_q || (byte_data != 8'h00);
              state_q    <= S_STOP;
            end
          end
        end
        S_STOP: begin
          // Halted until reset
          state_q <= S_STOP;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// File: dpl_loader_chk.sv
// Purpose: Port checks for the loader
// Assumes: One clock, async active-low reset
// Notes:   Bound to every loader
`timescale 1ns/1ps
module dpl_loader_chk (
  // Inputs, plus the byte_ready output
  input wire        clock,
  input wire        resetn,
  input wire        blk_start,
  input wire        blk_term,
  input wire        byte_valid,
  input wire [7:0]  byte_data,
  input wire        byte_ready,
  // Outputs
  input wire        pm_we,
  input wire [55:0] pm_data,
  input wire        busy,
  input wire        pm_done,
  input wire        pm_error,
  input wire        load_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire tk = blk_start & ~busy & ~load_done;
  property p_ln; pm_we |-> pm_data[55:48] == {2'h0, $past(byte_data[5:0])}; endproperty
  a_ln: assert property (p_ln) else $error("lane");
  property p_wc; pm_we |-> $past(byte_valid & byte_ready); endproperty
  a_wc: assert property (p_wc) else $error("write");
  property p_pl; pm_we |=> !pm_we [*6]; endproperty
  a_pl: assert property (p_pl) else $error("pulse");
  property p_st; tk |=> busy & byte_ready; endproperty
  a_st: assert property (p_st) else $error("start");
  property p_er; tk & ~blk_term |=> pm_error & ~pm_done; endproperty
  a_er: assert property (p_er) else $error("err");
  property p_ex; pm_done |-> !pm_error; endproperty
  a_ex: assert property (p_ex) else $error("excl");
  property p_hl; load_done |=> load_done & ~busy & ~byte_ready; endproperty
  a_hl: assert property (p_hl) else $error("halt");
  property p_fn; $fell(busy) |-> $past(byte_valid & byte_ready); endproperty
  a_fn: assert property (p_fn) else $error("end");
  c_we: cover property (pm_we);
  c_dn: cover property (pm_done);
  c_ld: cover property (load_done);
endmodule
bind dpl_loader dpl_loader_chk chk_u (
  .clock      (clock),
  .resetn     (resetn),
  .blk_start  (blk_start),
  .blk_term   (blk_term),
  .byte_valid (byte_valid),
  .byte_data  (byte_data),
  .byte_ready (byte_ready),
  .pm_we      (pm_we),
  .pm_data    (pm_data),
  .busy       (busy),
  .pm_done    (pm_done),
  .pm_error   (pm_error),
  .load_done  (load_done)
);

// File: dpl_rom_model.sv
// Purpose: Boot image source
// Assumes: Bench fills mem first
// Notes:   Idle data toggles each cycle between the last byte and its inverse
`timescale 1ns/1ps
module dpl_rom_model (
  // Control
  input wire       clock,
  input wire       go,
  input wire       stall,
  input wire [6:0] n,
  // Stream
  input wire       byte_ready,
  output reg       byte_valid = 1'b0,
  output reg [7:0] byte_data = 8'h00
);
  reg [7:0] mem [0:63];
  reg [6:0] idx = 7'h00;
  always @(posedge clock)
    idx <= !go ? 7'h00 : idx + {6'h00, byte_valid & byte_ready};
  always @(negedge clock) begin
    byte_valid <= go & ~stall & (idx < n);
    byte_data <= (go & ~stall & (idx < n)) ? mem[idx] : ~byte_data;
  end
endmodule

// File: dsp_program_image_loader_tb.sv
// Purpose: Bench for the loader
// Assumes: Image source model feeds bytes
// Notes:   Inputs move on falling edges
`timescale 1ns/1ps
module dsp_program_image_loader_tb;
  reg clock = 1'b0, resetn = 1'b0, blk_start = 1'b0, blk_term = 1'b0;
  reg go = 1'b0, stall = 1'b0, slow = 1'b0;
  reg [15:0] blk_words = 16'h0000, blk_sum_init = 16'h0123, sum;
  reg [55:0] got [0:7];
  wire byte_valid, byte_ready, pm_we, busy, pm_done, pm_error, term_error, load_done;
  wire [7:0] byte_data;
  wire [11:0] pm_addr;
  wire [55:0] pm_data;
  integer errors = 0, n_compared = 0, cyc = 0, k = 0, nw = 0, i;
  dpl_loader dut_u (
    .clock        (clock),
    .resetn       (resetn),
    .blk_start    (blk_start),
    .blk_term     (blk_term),
    .blk_words    (blk_words),
    .blk_sum_init (blk_sum_init),
    .byte_valid   (byte_valid),
    .byte_data    (byte_data),
    .byte_ready   (byte_ready),
    .pm_we        (pm_we),
    .pm_addr      (pm_addr),
    .pm_data      (pm_data),
    .busy         (busy),
    .pm_done      (pm_done),
    .pm_error     (pm_error),
    .term_error   (term_error),
    .load_done    (load_done)
  );
  dpl_rom_model rom_u (
    .clock      (clock),
    .go         (go),
    .stall      (stall),
    .n          (k[6:0]),
    .byte_ready (byte_ready),
    .byte_valid (byte_valid),
    .byte_data  (byte_data)
  );
  initial forever #2 clock = ~clock;
  always @(negedge clock) stall <= slow & ~stall;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (pm_we) got[nw] <= pm_data;
    if (pm_we) nw <= nw + 1;
    if (cyc == 3000) errors = errors + 1;
    if (cyc == 3000) wrap_up;
  end
  task chk(input string s, input [55:0] e, input [55:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", s, e, g);
    end
  endtask
  task put(input [7:0] b);
    rom_u.mem[k] = b;
    k++;
    sum += b;
  endtask
  task run(input t, input [15:0] z);
    {blk_term, blk_words, blk_start} = {t, z, 1'b1};
    go <= 1'b1;
    @(negedge clock) blk_start = 1'b0;
    while (busy !== 1'b0) @(negedge clock);
    go <= 1'b0;
    @(negedge clock);
  endtask
  task t_prog(input integer z, input bad);
    reg [55:0] e;
    integer w, j, b0;
    {k, b0, sum} = {32'h0, nw, 16'hff00 + z[15:0]};
    blk_sum_init = sum;
    for (w = 0; w < 7 * z; w++) put(8'h80 + w[7:0]);
    e[15:0] = sum + {15'h0, bad};
    for (w = 0; w < 7; w++) put(w < 5 ? 8'h00 : (w == 5 ? e[15:8] : e[7:0]));
    run(1'b0, z[15:0]);
    for (w = 0; w < z; w++) begin
      for (j = 0; j < 7; j++) e[8*j+:8] = 8'h80 + 7 * w + j;
      e[55:54] = 2'h0;
      chk("word", e, got[b0 + w]);
    end
    chk("words", b0 + z, nw);
    chk("done", !bad, pm_done);
    chk("error", bad, pm_error);
  endtask
  task t_bad_term(input integer p);
    k = 0;
    for (i = 0; i < 20; i++) put(i == 3 ? 8'h1f : {7'h0, i == p});
    run(1'b1, 16'h0000);
    chk("halt", 1, load_done);
    chk("term", 1, term_error);
    resetn = 1'b0;
    @(negedge clock) resetn = 1'b1;
    chk("reset", 0, {load_done, term_error, busy, pm_error, pm_addr});
  endtask
  task t_term;
    k = 0;
    for (i = 0; i < 20; i++) put(i == 3 ? 8'h1f : 8'h00);
    run(1'b1, 16'h0000);
    chk("halt", 1, load_done);
    chk("term", 0, term_error);
    chk("addr", 2, pm_addr);
    blk_start = 1'b1;
    @(negedge clock) blk_start = 1'b0;
    chk("refused", 0, busy);
  endtask
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    slow <= 1'b1;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    t_bad_term(12);
    t_bad_term(19);
    t_prog(2, 1'b0);
    slow <= 1'b0;
    t_prog(1, 1'b1);
    t_prog(0, 1'b0);
    t_term;
    wrap_up;
  end
endmodule
